// ==== smt_pkg.sv ====
// smt_pkg: shared constants of the speech message trigger control block.
// assumes one 125 MHz clock; all timing figures are turned into cycle counts here.
package smt_pkg;
   // clock
   localparam int unsigned CLK_PERIOD_NS = 8;
   // idle time before standby, in milliseconds (product sized to 64 bits)
   localparam longint unsigned IDLE_TIME_MS = 64'd3000;
   localparam longint unsigned IDLE_CYCLES_L = (IDLE_TIME_MS * 64'd1000000) / CLK_PERIOD_NS;
   // output sample period in nanoseconds (plain default, 8 kHz)
   localparam longint unsigned SAMPLE_PERIOD_NS = 64'd125000;
   localparam longint unsigned SAMPLE_CYCLES_L = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   // widths
   localparam int unsigned CODE_W = 8;
   localparam int unsigned SAMPLE_W = 9;
   localparam int unsigned OFFSET_W = 6;
   localparam int unsigned TIMER_W = 32;
   // stored word: end-of-message flag above the sample
   localparam int unsigned WORD_LAST_BIT = 9;
   localparam int unsigned WORD_W = 10;
   // reset values
   localparam logic [CODE_W-1:0] CODE_RST = 8'h00;
   localparam logic [SAMPLE_W-1:0] SAMPLE_RST = 9'h100;
   // control states, gray coded along idle, armed, fetch, play, standby
   typedef enum logic [2:0] {
      SMT_IDLE = 3'b000,
      SMT_ARMED = 3'b001,
      SMT_FETCH = 3'b011,
      SMT_PLAY = 3'b010,
      SMT_STANDBY = 3'b110
   } smt_state_t;
endpackage

// ==== smt_msg_rom.sv ====
// smt_msg_rom: built-in sample store, one block of words per message code.
// assumes the caller waits one cycle for data; contents are a fixed pattern.
module smt_msg_rom
   import smt_pkg::*;
#(
   parameter int unsigned ADDR_W = CODE_W + OFFSET_W,
   parameter int unsigned MSG_LEN = 48
) (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic [ADDR_W-1:0] addr_i,
   output logic [WORD_W-1:0] data_o
);
   // table contents derived from the address; stands in for programmed data
   function automatic logic [WORD_W-1:0] rom_word(input logic [ADDR_W-1:0] a);
      logic last;
      logic [SAMPLE_W-1:0] s;
      last = (a[OFFSET_W-1:0] == OFFSET_W'(MSG_LEN - 1));
      s = {a[ADDR_W-1 -: CODE_W], a[0]} ^ 9'h100;
      return {last, s};
   endfunction

   wire logic [WORD_W-1:0] next_data = rom_word(addr_i);

   // registered read port
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         data_o <= '0;
      end else begin
         data_o <= next_data;
      end
   end
endmodule // smt_msg_rom

// ==== smt_trigger.sv ====
// What this block does
// - latch select code at start rise, chip-selected
// - start low with select low plays message
// - qualified start in standby wakes and plays
// - busy low as soon as start accepted
// - busy high with the last sample output, not before
// - starts ignored while busy; no relatch
// - busy floats in standby, driven otherwise
// - reset aborts playback and leaves standby
// - idle over three seconds enters standby
// - select with start, or reset, wakes
// - eight-bit code picks one of 256 messages
// - samples leave as unsigned nine-bit values
//
// smt_trigger: start/busy/standby control and sample playback of the synthesizer.
// assumes inputs synchronous to CLK_I; the host ties the busy pin up while it floats.
module smt_trigger
   import smt_pkg::*;
#(
   parameter int unsigned IDLE_CYCLES = 32'(IDLE_CYCLES_L),
   parameter int unsigned SAMPLE_CYCLES = 32'(SAMPLE_CYCLES_L),
   parameter int unsigned MSG_LEN = 48
) (
   input wire logic CLK_I,
   input wire logic RSTN_I,
   input wire logic CHIP_SEL_N_I,
   input wire logic START_STROBE_N_I,
   input wire logic [CODE_W-1:0] MESSAGE_SELECT_CODE_I,
   output logic BUSY_N_O,
   output logic BUSY_N_OE_N_O,
   output logic [SAMPLE_W-1:0] SAMPLE_O,
   output logic SAMPLE_VALID_O,
   output logic STANDBY_O
);
   localparam int unsigned ADDR_W = CODE_W + OFFSET_W;

   smt_state_t state;
   smt_state_t next_state;
   logic start_n_q;
   logic [CODE_W-1:0] msg_code;
   logic [OFFSET_W-1:0] offset;
   logic [TIMER_W-1:0] idle_cnt;
   logic [TIMER_W-1:0] pace_cnt;
   logic [WORD_W-1:0] rom_q;
   logic [TIMER_W-1:0] gap_cnt;

   // input qualification
   wire logic qual_low = !START_STROBE_N_I && !CHIP_SEL_N_I;
   wire logic start_rise = START_STROBE_N_I && !start_n_q;
   wire logic activity = !CHIP_SEL_N_I || !START_STROBE_N_I;
   wire logic idle_done = (idle_cnt == TIMER_W'(IDLE_CYCLES - 1));
   wire logic pace_tick = (pace_cnt == '0);
   wire logic last_word = rom_q[WORD_LAST_BIT];
   wire logic [ADDR_W-1:0] rom_addr = {msg_code, offset};

   // sample store
   smt_msg_rom #(
      .ADDR_W(ADDR_W),
      .MSG_LEN(MSG_LEN)
   ) u_rom (
      .clk_i(CLK_I),
      .rstn_i(RSTN_I),
      .addr_i(rom_addr),
      .data_o(rom_q)
   );

   // state transitions; busy states never look at a new start
   always_comb begin
      next_state = state;
      case (state)
         SMT_IDLE: begin
            if (qual_low) begin
               next_state = SMT_ARMED;
            end else if (idle_done && !activity) begin
               next_state = SMT_STANDBY;
            end
         end
         SMT_STANDBY: begin
            if (qual_low) begin
               next_state = SMT_ARMED;
            end
         end
         SMT_ARMED: begin
            if (start_rise) begin
               next_state = SMT_FETCH;
            end
         end
         SMT_FETCH: begin
            next_state = SMT_PLAY;
         end
         SMT_PLAY: begin
            if (pace_tick && last_word) begin
               next_state = SMT_IDLE;
            end
         end
         default: begin
            next_state = SMT_IDLE;
         end
      endcase
   end

   // reset drops everything, playback and standby alike
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         state <= SMT_IDLE;
         start_n_q <= 1'b1;
      end else begin
         state <= next_state;
         start_n_q <= START_STROBE_N_I;
      end
   end

   // code is only taken on the rise that ends the accepted strobe
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         msg_code <= CODE_RST;
      end else if (state == SMT_ARMED && start_rise) begin
         msg_code <= MESSAGE_SELECT_CODE_I;
      end
   end

   // idle timer, restarted by select, start or reset
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         idle_cnt <= '0;
      end else if (state != SMT_IDLE || activity) begin
         idle_cnt <= '0;
      end else if (!idle_done) begin
         idle_cnt <= idle_cnt + 1'b1;
      end
   end

   // playback pacing; offset is cleared outside play so fetch always reads word 0
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         offset <= '0;
         pace_cnt <= '0;
         SAMPLE_O <= SAMPLE_RST;
         SAMPLE_VALID_O <= 1'b0;
      end else begin
         SAMPLE_VALID_O <= 1'b0;
         if (state != SMT_PLAY) begin
            offset <= '0;
            pace_cnt <= '0;
         end else begin
            if (pace_tick) begin
               SAMPLE_O <= rom_q[SAMPLE_W-1:0];
               SAMPLE_VALID_O <= 1'b1;
               offset <= offset + 1'b1;
               pace_cnt <= TIMER_W'(SAMPLE_CYCLES - 1);
            end else begin
               pace_cnt <= pace_cnt - 1'b1;
            end
         end
      end
   end

   // cycles since the last sample pulse; saturates so a long idle never wraps
   always_ff @(posedge CLK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         gap_cnt <= '0;
      end else if (SAMPLE_VALID_O) begin
         gap_cnt <= '0;
      end else if (gap_cnt != '1) begin
         gap_cnt <= gap_cnt + 1'b1;
      end
   end

   // pin drive: low-true busy, floated only in standby
   assign BUSY_N_O = (state == SMT_IDLE || state == SMT_STANDBY);
   assign BUSY_N_OE_N_O = (state == SMT_STANDBY);
   assign STANDBY_O = (state == SMT_STANDBY);

   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RSTN_I);

   busy_on_start_a: assert property ((state == SMT_IDLE) && qual_low
         |=> !BUSY_N_O && !BUSY_N_OE_N_O)
      else $error("busy not low after accepted start");
   code_latch_a: assert property ((state == SMT_ARMED) && start_rise
         |=> msg_code == $past(MESSAGE_SELECT_CODE_I))
      else $error("message code not captured at start rise");
   no_relatch_a: assert property ((state == SMT_FETCH || state == SMT_PLAY)
         |=> $stable(msg_code) && state != SMT_ARMED)
      else $error("start accepted while busy");
   busy_float_a: assert property ((state == SMT_STANDBY)
         |-> BUSY_N_OE_N_O && STANDBY_O ##0 (!qual_low or ##1 !BUSY_N_OE_N_O))
      else $error("busy pin enable wrong around standby");
   wake_play_a: assert property ((state == SMT_STANDBY) && qual_low ##1 start_rise
         |=> ##1 state == SMT_PLAY)
      else $error("standby start did not lead to playback");
   end_release_a: assert property ((state == SMT_PLAY) && pace_tick && last_word
         |=> BUSY_N_O ##0 SAMPLE_VALID_O)
      else $error("busy not released with last sample");
   busy_hold_a: assert property ((state == SMT_PLAY) && !(pace_tick && last_word)
         |=> !BUSY_N_O)
      else $error("busy released before message end");
   standby_entry_a: assert property ((state == SMT_IDLE) && idle_done && !activity
         |=> STANDBY_O)
      else $error("idle timeout did not enter standby");
   timer_restart_a: assert property (activity |=> idle_cnt == '0)
      else $error("idle timer not restarted by activity");
   fetch_addr_a: assert property ((state == SMT_FETCH)
         |-> rom_addr == {msg_code, {OFFSET_W{1'b0}}})
      else $error("message block address wrong");
   sample_out_a: assert property (SAMPLE_VALID_O
         |-> SAMPLE_O == $past(rom_q[SAMPLE_W-1:0]))
      else $error("sample output does not match stored word");

   // pin levels, wake path, timer steps and sample spacing
   armed_busy_a: assert property ((state == SMT_ARMED)
         |-> !BUSY_N_O && !BUSY_N_OE_N_O)
      else $error("busy not driven low while armed");
   pin_driven_a: assert property (!STANDBY_O |-> !BUSY_N_OE_N_O)
      else $error("busy pin floated outside standby");
   wake_arm_a: assert property ((state == SMT_STANDBY) && qual_low
         |=> state == SMT_ARMED && !STANDBY_O)
      else $error("qualified start did not leave standby");
   fetch_play_a: assert property ((state == SMT_FETCH)
         |=> state == SMT_PLAY ##1 SAMPLE_VALID_O)
      else $error("playback did not start after fetch");
   timer_step_a: assert property ((state == SMT_IDLE) && !activity && !idle_done
         |=> idle_cnt == $past(idle_cnt) + 1'b1)
      else $error("idle timer did not advance");
   sample_gap_a: assert property (SAMPLE_VALID_O && offset != OFFSET_W'(1)
         |-> gap_cnt == TIMER_W'(SAMPLE_CYCLES - 1))
      else $error("sample spacing wrong");
endmodule // smt_trigger

// ==== smt_host_model.sv ====
// smt_host_model: host driving message code and chip-selected start; resolves busy pin.
// assumes a pull-up on the busy pin while the device floats it.
module smt_host_model
   import smt_pkg::*;
(
   input wire logic clk_i,
   input wire logic busy_n_i,
   input wire logic busy_oe_n_i,
   output logic cs_n_o,
   output logic st_n_o,
   output logic [CODE_W-1:0] code_o,
   output logic busy_pin_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      cs_n_o = 1'b1;
      st_n_o = 1'b1;
      code_o = '0;
   end
   // pull-up wins while the device floats the pin
   assign busy_pin_o = busy_oe_n_i ? 1'b1 : busy_n_i;
   // start low under select, code held past the rising edge
   task automatic start(input logic [CODE_W-1:0] code);
      @(posedge clk_i) #1;
      code_o = code;
      cs_n_o = 1'b0;
      st_n_o = 1'b0;
      @(posedge clk_i) #1;
      st_n_o = 1'b1;
      @(posedge clk_i) #1;
      cs_n_o = 1'b1;
      code_o = ~code; // released bus must not show a stale code
   endtask
   // lone select pulse: activity without a start
   task automatic poke();
      @(posedge clk_i) #1;
      cs_n_o = 1'b0;
      @(posedge clk_i) #1;
      cs_n_o = 1'b1;
   endtask
endmodule // smt_host_model

// ==== tb_top.sv ====
// tb_top: self-checking bench of the trigger control with short idle and sample counts.
// assumes smt_pkg and the design files are compiled first.
module tb_top
   import smt_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned IDLE_N = 50;
   localparam int unsigned LEN_N = 4;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic cs_n, st_n, busy_n, oe_n, valid, standby, busy_pin;
   logic [CODE_W-1:0] code;
   logic [SAMPLE_W-1:0] sample;
   int failures = 0;
   int check_count = 0;
   initial forever #4 clk = ~clk;
   smt_trigger #(.IDLE_CYCLES(IDLE_N), .SAMPLE_CYCLES(4), .MSG_LEN(LEN_N)) dut_u (
      .CLK_I(clk), .RSTN_I(rstn), .CHIP_SEL_N_I(cs_n), .START_STROBE_N_I(st_n),
      .MESSAGE_SELECT_CODE_I(code), .BUSY_N_O(busy_n), .BUSY_N_OE_N_O(oe_n),
      .SAMPLE_O(sample), .SAMPLE_VALID_O(valid), .STANDBY_O(standby));
   smt_host_model host_u (.clk_i(clk), .busy_n_i(busy_n), .busy_oe_n_i(oe_n),
      .cs_n_o(cs_n), .st_n_o(st_n), .code_o(code), .busy_pin_o(busy_pin));
   task automatic check(input logic [SAMPLE_W-1:0] seen, input logic [SAMPLE_W-1:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // hold well past the twelve-clock minimum
   task automatic do_reset();
      @(posedge clk) #1;
      rstn = 1'b0;
      #2 check(9'(standby), 9'h0);
      check(9'(busy_n), 9'h1);
      check(sample, 9'h100);
      repeat (16) @(posedge clk);
      #1 rstn = 1'b1;
   endtask
   // count every sample of one message and its value
   task automatic collect(input logic [CODE_W-1:0] c);
      int n;
      n = 0;
      for (int i = 0; i < 200 && n < LEN_N; i++) begin
         @(posedge clk) #2;
         if (valid === 1'b1) begin
            check(sample, {c, n[0]} ^ 9'h100);
            n++;
            check(9'(busy_n), 9'(n == LEN_N));
         end
      end
      check(9'(n), 9'(LEN_N));
   endtask
   task automatic t_play();
      logic [CODE_W-1:0] codes [3] = '{8'h00, 8'hff, 8'h5a};
      foreach (codes[k]) begin
         host_u.start(codes[k]);
         check(9'(busy_n), 9'h0);
         collect(codes[k]);
      end
   endtask
   // second start in mid-play must neither relatch nor replay
   task automatic t_refuse();
      host_u.start(8'h21);
      fork
         collect(8'h21);
         begin
            repeat (4) @(posedge clk);
            host_u.start(8'hc3);
         end
      join
      repeat (12) begin
         @(posedge clk) #2;
         check(9'(valid), 9'h0);
      end
   endtask
   task automatic t_standby();
      repeat (IDLE_N + 10) @(posedge clk);
      #2 check(9'(standby), 9'h1);
      check(9'(oe_n), 9'h1);
      check(9'(busy_pin), 9'h1);
      host_u.start(8'h7e);
      check(9'(standby), 9'h0);
      check(9'(oe_n), 9'h0);
      collect(8'h7e);
   endtask
   // abort in mid-play, timer restart on activity, reset out of standby
   task automatic t_reset();
      host_u.start(8'h44);
      repeat (6) @(posedge clk);
      do_reset();
      repeat (IDLE_N - 10) @(posedge clk);
      host_u.poke();
      repeat (IDLE_N - 10) @(posedge clk);
      #2 check(9'(standby), 9'h0);
      repeat (20) @(posedge clk);
      #2 check(9'(standby), 9'h1);
      do_reset();
   endtask
   task automatic final_report();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      do_reset();
      t_play();
      t_refuse();
      t_standby();
      t_reset();
      final_report();
   end
   // runs are a few thousand ns; this only catches a hang
   initial begin
      #20000;
      failures++;
      final_report();
   end
endmodule // tb_top
